// ==== rwds_ctrl_model.sv ====
// exposure pin driver standing in for the camera controller
`timescale 1ns/100ps
module rwds_ctrl_model (
    // clock, reset, request
    input wire       MCLK, RSTN, go,
    // exposure length and second reset moment
    input wire [7:0] len, slope_at,
    // exposure pins
    output reg       EXPOSURE_1, EXPOSURE_2
);
    reg [7:0] cnt;
    always @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            EXPOSURE_1 <= 1'b0;
            EXPOSURE_2 <= 1'b0;
            cnt <= 8'h00;
        end else if (go) begin
            EXPOSURE_1 <= 1'b1;
            cnt <= 8'h00;
        end else if (EXPOSURE_1) begin
            cnt <= cnt + 8'h01;
            EXPOSURE_2 <= (cnt >= slope_at) && (cnt < slope_at + 8'h04);
            if (cnt == len)
                EXPOSURE_1 <= 1'b0;
        end
    end
endmodule // rwds_ctrl_model

// ==== rwds_defs.vh ====
// constants for the readout window and dual slope block
`ifndef RWDS_DEFS_VH
`define RWDS_DEFS_VH
`define RWDS_ADDR_XSTART    12'h000
`define RWDS_ADDR_XKERN     12'h004
`define RWDS_ADDR_YSTART    12'h008
`define RWDS_ADDR_YEND      12'h00c
`define RWDS_ADDR_ROWOH     12'h010
`define RWDS_ADDR_CTRL      12'h014
`define RWDS_ADDR_STATUS    12'h018
`define RWDS_ADDR_POS       12'h01c
`define RWDS_RST_XSTART     8'h01
`define RWDS_RST_XKERN      8'h35
`define RWDS_RST_YSTART     12'h000
`define RWDS_RST_YEND       12'h6ad
`define RWDS_RST_ROWOH      8'h09
`define RWDS_MIN_KERNELS    8'h04
`define RWDS_SENSOR_DIV     2'h3
`define RWDS_CTRL_RUN       0
`define RWDS_ST_BUSY        0
`define RWDS_ST_EXPOSE      1
`define RWDS_ST_SLOPE2      2
`define RWDS_ST_BADWIN      3
`define RWDS_ST_BADPAR      4
`define RWDS_ST_DONE        5
`endif

// ==== rwds_properties.sv ====
// assertion checker for the readout window block
`timescale 1ns/100ps
module rwds_chk #(parameter KW = 8, parameter RW = 12) (
    // pins and array access
    input wire          MCLK, RSTN, EXPOSURE_1, EXPOSURE_2, PIX_RESET, PIX_RESET2,
    input wire          ACCESS_VALID, ROW_OVERHEAD, SENSOR_TICK,
    input wire [RW-1:0] ACCESS_ROW,
    input wire [KW-1:0] ACCESS_KERNEL
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RSTN);
    a_tick_period: assert property (SENSOR_TICK |=> !SENSOR_TICK [*3] ##1 SENSOR_TICK) else $error("tick");
    a_slope_excl: assert property (PIX_RESET2 |-> !PIX_RESET) else $error("reset2");
    a_exp2_off: assert property (!EXPOSURE_2 [*4] |-> !PIX_RESET2) else $error("exp2");
    a_exp1_off: assert property (!EXPOSURE_1 [*4] |-> PIX_RESET) else $error("exp1");
    a_odd_start: assert property ($rose(ACCESS_VALID) |-> ACCESS_KERNEL[0]) else $error("start");
    a_kernel_step: assert property (ACCESS_VALID && $past(ACCESS_VALID) && $changed(ACCESS_KERNEL)
        |-> ACCESS_KERNEL - $past(ACCESS_KERNEL) == 1) else $error("step");
    a_row_hold: assert property (ACCESS_VALID && $past(ACCESS_VALID) |-> $stable(ACCESS_ROW)) else $error("row");
    a_phase_excl: assert property (!(ACCESS_VALID && ROW_OVERHEAD)) else $error("phase");
    a_oh_first: assert property ($rose(ACCESS_VALID) |-> $past(ROW_OVERHEAD)) else $error("overhead");
    c_scan: cover property ($rose(ACCESS_VALID));
    c_slope: cover property ($rose(PIX_RESET2));
    c_oh: cover property ($fell(ROW_OVERHEAD));
endmodule // rwds_chk
bind rwds_top rwds_chk #(.KW(KW), .RW(RW)) u_chk (.MCLK, .RSTN, .EXPOSURE_1, .EXPOSURE_2, .PIX_RESET,
    .PIX_RESET2, .ACCESS_VALID, .ROW_OVERHEAD, .SENSOR_TICK, .ACCESS_ROW, .ACCESS_KERNEL);

// ==== rwds_sync.v ====
// two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module rwds_sync (
    // clock and reset
    input  wire MCLK,
    input  wire RSTN,
    // data
    input  wire D,
    output wire Q
);
    reg meta;
    reg stage;
    always @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            meta  <= 1'b0;
            stage <= 1'b0;
        end else begin
            meta  <= D;
            stage <= meta;
        end
    end
    assign Q = stage;
endmodule // rwds_sync

// ==== rwds_top.v ====
// readout window sequencer with apb registers and dual slope exposure pins
`timescale 1ns/100ps
`include "rwds_defs.vh"
module rwds_top #(
    parameter KW = 8,
    parameter RW = 12
) (
    // clock and reset
    input  wire          MCLK,
    input  wire          RSTN,
    // apb slave
    input  wire          PSEL,
    input  wire          PENABLE,
    input  wire          PWRITE,
    input  wire [11:0]   PADDR,
    input  wire [31:0]   PWDATA,
    output reg  [31:0]   PRDATA,
    output wire          PREADY,
    output wire          PSLVERR,
    // exposure pins from controller
    input  wire          EXPOSURE_1,
    input  wire          EXPOSURE_2,
    // pixel array access
    output reg           PIX_RESET,
    output reg           PIX_RESET2,
    output reg           ACCESS_VALID,
    output reg  [RW-1:0] ACCESS_ROW,
    output reg  [KW-1:0] ACCESS_KERNEL,
    output reg           ROW_OVERHEAD,
    output reg           SENSOR_TICK
);
    localparam S_IDLE = 2'h0;
    localparam S_ROH  = 2'h1;
    localparam S_READ = 2'h2;

    reg [KW-1:0] x_start;
    reg [KW-1:0] kernel_count_setting;
    reg [RW-1:0] y_start;
    reg [RW-1:0] y_end;
    reg [KW-1:0] row_overhead_count;
    reg          run;
    reg          done;
    reg [1:0]    state;
    reg [1:0]    div;
    reg [KW-1:0] kcnt;
    reg [KW-1:0] ocnt;
    reg          exp1_d;
    reg          exp2_d;
    wire         exp1;
    wire         exp2;
    wire         tick;
    wire         bad_win;
    wire         bad_par;
    wire         wr;
    wire [KW-1:0] sum_par;
    wire         rd_setup;
    reg [31:0]   next_prdata;
    reg [31:0]   status_word;

    rwds_sync u_sync1 (.MCLK(MCLK), .RSTN(RSTN), .D(EXPOSURE_1), .Q(exp1));
    rwds_sync u_sync2 (.MCLK(MCLK), .RSTN(RSTN), .D(EXPOSURE_2), .Q(exp2));

    assign PREADY  = 1'b1;
    assign PSLVERR = 1'b0;
    assign wr      = PSEL & PENABLE & PWRITE;
    assign rd_setup = PSEL & ~PENABLE & ~PWRITE;
    assign tick    = (div == `RWDS_SENSOR_DIV);
    assign sum_par = row_overhead_count + kernel_count_setting;
    assign bad_par = sum_par[0];
    assign bad_win = (kernel_count_setting < `RWDS_MIN_KERNELS) | (y_end < y_start) | ~x_start[0];

    // register writes
    always @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            x_start              <= `RWDS_RST_XSTART;
            kernel_count_setting <= `RWDS_RST_XKERN;
            y_start              <= `RWDS_RST_YSTART;
            y_end                <= `RWDS_RST_YEND;
            row_overhead_count   <= `RWDS_RST_ROWOH;
            run                  <= 1'b0;
        end else if (wr) begin
            case (PADDR)
                `RWDS_ADDR_XSTART: x_start <= {PWDATA[KW-1:1], 1'b1};
                `RWDS_ADDR_XKERN:  kernel_count_setting <= PWDATA[KW-1:0];
                `RWDS_ADDR_YSTART: y_start <= PWDATA[RW-1:0];
                `RWDS_ADDR_YEND:   y_end <= PWDATA[RW-1:0];
                `RWDS_ADDR_ROWOH:  row_overhead_count <= PWDATA[KW-1:0];
                `RWDS_ADDR_CTRL:   run <= PWDATA[`RWDS_CTRL_RUN];
                default: begin
                end
            endcase
        end
    end

    // status word from its field positions
    always @* begin
        status_word                  = 32'h0;
        status_word[`RWDS_ST_BUSY]   = (state != S_IDLE);
        status_word[`RWDS_ST_EXPOSE] = exp1;
        status_word[`RWDS_ST_SLOPE2] = PIX_RESET2;
        status_word[`RWDS_ST_BADWIN] = bad_win;
        status_word[`RWDS_ST_BADPAR] = bad_par;
        status_word[`RWDS_ST_DONE]   = done;
    end

    // register read mux
    always @* begin
        case (PADDR)
            `RWDS_ADDR_XSTART: next_prdata = {{(32-KW){1'b0}}, x_start};
            `RWDS_ADDR_XKERN:  next_prdata = {{(32-KW){1'b0}}, kernel_count_setting};
            `RWDS_ADDR_YSTART: next_prdata = {{(32-RW){1'b0}}, y_start};
            `RWDS_ADDR_YEND:   next_prdata = {{(32-RW){1'b0}}, y_end};
            `RWDS_ADDR_ROWOH:  next_prdata = {{(32-KW){1'b0}}, row_overhead_count};
            `RWDS_ADDR_CTRL:   next_prdata = {31'h0, run};
            `RWDS_ADDR_STATUS: next_prdata = status_word;
            `RWDS_ADDR_POS:    next_prdata = {{(16-RW){1'b0}}, ACCESS_ROW, {(16-KW){1'b0}}, ACCESS_KERNEL};
            default:           next_prdata = 32'h0;
        endcase
    end

    // read data latched in setup, stands through the access phase
    always @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            PRDATA <= 32'h0;
        end else if (rd_setup) begin
            PRDATA <= next_prdata;
        end
    end

    // sensor clock and exposure pins
    always @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            div         <= 2'h0;
            SENSOR_TICK <= 1'b0;
            exp1_d      <= 1'b0;
            exp2_d      <= 1'b0;
            PIX_RESET   <= 1'b1;
            PIX_RESET2  <= 1'b0;
        end else begin
            div         <= div + 2'h1;
            SENSOR_TICK <= tick;
            exp1_d      <= exp1;
            exp2_d      <= exp2;
            PIX_RESET   <= ~(run & exp1);
            PIX_RESET2  <= run & exp1 & exp2;
        end
    end

    // window scan
    always @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            state         <= S_IDLE;
            kcnt          <= {KW{1'b0}};
            ocnt          <= {KW{1'b0}};
            ACCESS_ROW    <= {RW{1'b0}};
            ACCESS_KERNEL <= {KW{1'b0}};
            ACCESS_VALID  <= 1'b0;
            ROW_OVERHEAD  <= 1'b0;
            done          <= 1'b0;
        end else begin
            if (!run) begin
                state        <= S_IDLE;
                ACCESS_VALID <= 1'b0;
                ROW_OVERHEAD <= 1'b0;
            end else begin
                case (state)
                    S_IDLE: begin
                        ACCESS_VALID <= 1'b0;
                        if (exp1_d & ~exp1 & ~bad_win) begin
                            state        <= S_ROH;
                            ACCESS_ROW   <= y_start;
                            ocnt         <= {KW{1'b0}};
                            ROW_OVERHEAD <= 1'b1;
                            done         <= 1'b0;
                        end
                    end
                    S_ROH: if (tick) begin
                        if (ocnt + 8'h01 >= row_overhead_count) begin
                            state         <= S_READ;
                            ROW_OVERHEAD  <= 1'b0;
                            ACCESS_KERNEL <= x_start;
                            kcnt          <= {KW{1'b0}};
                            ACCESS_VALID  <= 1'b1;
                        end else begin
                            ocnt <= ocnt + 8'h01;
                        end
                    end
                    S_READ: if (tick) begin
                        if (kcnt + 8'h01 >= kernel_count_setting) begin
                            ACCESS_VALID <= 1'b0;
                            if (ACCESS_ROW >= y_end) begin
                                state <= S_IDLE;
                                done  <= 1'b1;
                            end else begin
                                ACCESS_ROW   <= ACCESS_ROW + 12'h001;
                                ocnt         <= {KW{1'b0}};
                                ROW_OVERHEAD <= 1'b1;
                                state        <= S_ROH;
                            end
                        end else begin
                            kcnt          <= kcnt + 8'h01;
                            ACCESS_KERNEL <= ACCESS_KERNEL + 8'h01;
                        end
                    end
                    default: state <= S_IDLE;
                endcase
            end
        end
    end
endmodule // rwds_top

// ==== tb_readout_window_and_dual_slope.sv ====
// self-checking bench for the readout window block
`timescale 1ns/100ps
`include "rwds_defs.vh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin mismatches++; \
    $display("mismatch at %0t got %h expected %h", $time, (a), (b)); end end
module tb_readout_window_and_dual_slope;
    reg         MCLK = 0, RSTN = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, go = 0;
    reg  [11:0] PADDR = 12'h000;
    reg  [31:0] PWDATA = 32'h0, r = 32'h0;
    wire [31:0] PRDATA;
    wire        PREADY, PSLVERR, EXPOSURE_1, EXPOSURE_2, PIX_RESET, PIX_RESET2, ACCESS_VALID, ROW_OVERHEAD;
    wire        SENSOR_TICK;
    wire [11:0] ACCESS_ROW;
    wire [7:0]  ACCESS_KERNEL;
    reg  [19:0] last = 20'hfffff;
    int         mismatches = 0, compares = 0, hits = 0, outside = 0, r2 = 0;
    rwds_top u_dut (.MCLK, .RSTN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
        .EXPOSURE_1, .EXPOSURE_2, .PIX_RESET, .PIX_RESET2, .ACCESS_VALID, .ACCESS_ROW, .ACCESS_KERNEL,
        .ROW_OVERHEAD, .SENSOR_TICK);
    rwds_ctrl_model u_ctl (.MCLK, .RSTN, .go, .len(8'h32), .slope_at(8'h2d), .EXPOSURE_1, .EXPOSURE_2);
    initial forever #20 MCLK = ~MCLK;
    always @(posedge MCLK) begin
        if (PIX_RESET2) r2++;
        if (ACCESS_VALID && {ACCESS_ROW, ACCESS_KERNEL} != last) begin
            hits++;
            last = {ACCESS_ROW, ACCESS_KERNEL};
            if (ACCESS_ROW < 2 || ACCESS_ROW > 3 || ACCESS_KERNEL < 3 || ACCESS_KERNEL > 7) outside++;
        end
    end
    task end_of_test;
        if (mismatches == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge MCLK);
        PSEL <= 1; PENABLE <= 0; PWRITE <= w; PADDR <= a; PWDATA <= d;
        @(posedge MCLK);
        PENABLE <= 1;
        for (n = 0; n < 16; n++) begin
            @(posedge MCLK);
            r = PRDATA;
            if (PREADY === 1'b1) break;
        end
        if (n == 16) begin mismatches++; end_of_test; end
        PSEL <= 0;
        PENABLE <= 0;
    endtask
    task rd(input logic [11:0] a, input logic [31:0] m, e);
        apb(0, a, 32'h0);
        `CHK(r & m, e)
    endtask
    task expose;
        @(posedge MCLK) go <= 1;
        @(posedge MCLK) go <= 0;
    endtask
    task t_regs;
        rd(`RWDS_ADDR_XKERN, 32'hff, {24'h0, `RWDS_RST_XKERN});
        rd(`RWDS_ADDR_YEND, 32'hfff, {20'h0, `RWDS_RST_YEND});
        rd(12'h020, 32'hffffffff, 32'h0);
        apb(1, `RWDS_ADDR_XSTART, 32'h2);
        rd(`RWDS_ADDR_XSTART, 32'hff, 32'h3);
        apb(1, `RWDS_ADDR_XKERN, 32'h4);
        apb(1, `RWDS_ADDR_ROWOH, 32'h2);
        rd(`RWDS_ADDR_STATUS, 32'h10, 32'h0);
        apb(1, `RWDS_ADDR_ROWOH, 32'h1);
        rd(`RWDS_ADDR_STATUS, 32'h10, 32'h10);
    endtask
    task t_scan;
        int n;
        apb(1, `RWDS_ADDR_XKERN, 32'h5);
        apb(1, `RWDS_ADDR_YSTART, 32'h2);
        apb(1, `RWDS_ADDR_YEND, 32'h3);
        apb(1, `RWDS_ADDR_CTRL, 32'h1);
        expose;
        r = 32'h0;
        for (n = 0; n < 100 && !r[5]; n++) apb(0, `RWDS_ADDR_STATUS, 32'h0);
        `CHK(r[5], 1'b1)
        if (!r[5]) end_of_test;
        `CHK(hits, 10)
        `CHK(outside, 0)
        `CHK(r2, 4)
    endtask
    task t_bad;
        int n;
        apb(1, `RWDS_ADDR_XKERN, 32'h3);
        rd(`RWDS_ADDR_STATUS, 32'h8, 32'h8);
        expose;
        for (n = 0; n < 200 && !(n > 2 && !EXPOSURE_1); n++) @(posedge MCLK);
        if (n == 200) begin mismatches++; end_of_test; end
        repeat (4) @(posedge MCLK);
        rd(`RWDS_ADDR_STATUS, 32'h1, 32'h0);
        `CHK(hits, 10)
    endtask
    initial begin
        repeat (12) @(posedge MCLK);
        RSTN <= 1;
        t_regs;
        t_scan;
        t_bad;
        end_of_test;
    end
endmodule // tb_readout_window_and_dual_slope
